// ### hw/tsc_defines.svh
// Constants for the two-wire temperature sensor target port and its master.
// Assumes a 200 MHz system clock; included by its bare name.
`ifndef TSC_DEFINES_SVH
`define TSC_DEFINES_SVH

// System clock rate and serial clock rate made by the master
`define TSC_CLK_HZ 200000000
`define TSC_SCL_HZ 400000
// System clocks per quarter of a serial clock period
`define TSC_QTR_CYC (`TSC_CLK_HZ / (`TSC_SCL_HZ * 4))
// Bus timeout in link-clock cycles (scl held low)
`define TSC_TOUT_CYC 1000000
// Device type code, value is arbitrary
`define TSC_DEV_TYPE 4'h5
// Bit count of a byte, and zero-based index of the last bit of a byte plus its acknowledge
`define TSC_BYTE_BITS 4'd8
`define TSC_LAST_BIT 4'd8
// Alarm output modes
`define TSC_ALM_INT 2'h0
`define TSC_ALM_CMP 2'h1
`define TSC_ALM_CRIT 2'h2

`endif

// ### hw/tsc_pkg.sv
// Types shared by both ends of the two-wire temperature sensor link.
// Assumes tsc_defines.svh for numeric constants.
package tsc_pkg;

  // Target-side link states
  typedef enum logic [6:0] {
    DS_IDLE   = 7'h01,
    DS_ADDR   = 7'h02,
    DS_ACK    = 7'h04,
    DS_RXD    = 7'h08,
    DS_TXD    = 7'h10,
    DS_TXACK  = 7'h20,
    DS_TXNEXT = 7'h40
  } tsc_dstate_t;

  // Master states
  typedef enum logic [3:0] {
    MS_IDLE  = 4'h1,
    MS_START = 4'h2,
    MS_BIT   = 4'h4,
    MS_STOP  = 4'h8
  } tsc_mstate_t;

  // Master user commands
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } tsc_cmd_t;

endpackage : tsc_pkg

// ### hw/tsc_i2c_if.sv
// Two-wire bus carrier joining the master end and the target end.
// Both lines are open drain with pull-ups; levels resolved here.
`timescale 1ns/1ps
interface tsc_i2c_if;
  logic scl;
  logic sda;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;

  // Wired-AND with pull-up: any enabled low driver wins
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface : tsc_i2c_if

// ### hw/tsc_target.sv
// Two-wire target port of the temperature sensor, plus alarm pin.
// Assumes a free-running link sample clock and a 200 MHz system clock.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_target
  import tsc_pkg::*;
#(
  parameter int unsigned TOUT_CYC = `TSC_TOUT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_LINK_CLK,
  tsc_i2c_if.dev bus,
  input wire logic [2:0] I_STRAP_ADDR,
  input wire logic [7:0] I_TX_DATA,
  input wire logic I_TX_WR,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_VALID,
  output logic O_RX_FIRST,
  output logic O_TX_TAKEN,
  output logic O_STOP,
  input wire logic I_TEMP_HIGH,
  input wire logic I_TEMP_LOW,
  input wire logic I_TEMP_CRIT,
  input wire logic [1:0] I_ALARM_MODE,
  input wire logic I_ALARM_CLR,
  output logic O_ALARM_O,
  output logic O_ALARM_OE
);

  // ---------------- Link clock domain ----------------
  logic [1:0] rst_s_r;
  logic lrst;
  logic [1:0] ln_s1_r, ln_s2_r, ln_h1_r, ln_h2_r;
  logic [1:0] ln_f_r, ln_q_r, ln_f_nxt;
  logic [2:0] strap_s1_r, strap_s2_r;
  logic [2:0] txw_s_r;
  logic scl_f, sda_f, scl_q, sda_q;
  logic scl_rise, scl_fall, start_ev, stop_ev, tmo;
  tsc_dstate_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt, txbuf_r, txbuf_nxt;
  logic [7:0] rx_hold_r, rx_hold_nxt;
  logic rx_first_r, rx_first_nxt, rw_r, rw_nxt, oe_r, oe_nxt;
  logic rx_tgl_r, rx_tgl_nxt, tk_tgl_r, tk_tgl_nxt, stp_tgl_r, stp_tgl_nxt;
  logic [19:0] tout_r, tout_nxt;
  // System domain signals read across
  logic [7:0] tx_hold_r;
  logic txw_tgl_r;

  // Reset and pin synchronisers, then three-sample glitch filter
  always_ff @(posedge I_LINK_CLK) begin
    rst_s_r <= {rst_s_r[0], I_SRST};
    ln_s1_r <= {bus.scl, bus.sda};
    ln_s2_r <= ln_s1_r;
    ln_h1_r <= ln_s2_r;
    ln_h2_r <= ln_h1_r;
    strap_s1_r <= I_STRAP_ADDR;
    strap_s2_r <= strap_s1_r;
    txw_s_r <= {txw_s_r[1:0], txw_tgl_r};
  end
  assign lrst = rst_s_r[1];

  // Filtered line levels accepted only when three samples agree
  always_comb begin
    ln_f_nxt = ln_f_r;
    if (ln_s2_r == ln_h1_r && ln_h1_r == ln_h2_r) begin
      ln_f_nxt = ln_s2_r;
    end
  end

  assign scl_f = ln_f_r[1];
  assign sda_f = ln_f_r[0];
  assign scl_q = ln_q_r[1];
  assign sda_q = ln_q_r[0];
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  // Data moves with clock steady high: condition, not data
  assign start_ev = scl_f && scl_q && sda_q && !sda_f;
  assign stop_ev = scl_f && scl_q && !sda_q && sda_f;
  assign tmo = !scl_f && (tout_r == 20'(TOUT_CYC - 1));

  // Bit and byte engine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    oe_nxt = oe_r;
    rw_nxt = rw_r;
    rx_hold_nxt = rx_hold_r;
    rx_first_nxt = rx_first_r;
    rx_tgl_nxt = rx_tgl_r;
    tk_tgl_nxt = tk_tgl_r;
    stp_tgl_nxt = stp_tgl_r;
    // New transmit byte captured once its toggle has crossed
    txbuf_nxt = (txw_s_r[2] != txw_s_r[1]) ? tx_hold_r : txbuf_r;
    tout_nxt = scl_f ? 20'h0 : (tmo ? tout_r : tout_r + 20'h1);
    if (start_ev) begin
      st_nxt = DS_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_ev || tmo) begin
      if (stop_ev && st_r != DS_IDLE) begin
        stp_tgl_nxt = !stp_tgl_r;
      end
      st_nxt = DS_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        DS_ADDR, DS_RXD: begin
          if (scl_rise && cnt_r != `TSC_BYTE_BITS) begin
            sh_nxt = {sh_r[6:0], sda_f};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == `TSC_BYTE_BITS) begin
            if (st_r == DS_ADDR &&
                sh_r[7:1] != {`TSC_DEV_TYPE, strap_s2_r}) begin
              st_nxt = DS_IDLE;
            end else begin
              oe_nxt = 1'b1;
              st_nxt = DS_ACK;
              if (st_r == DS_ADDR) begin
                rw_nxt = sh_r[0];
              end
              rx_hold_nxt = sh_r;
              rx_first_nxt = (st_r == DS_ADDR);
              rx_tgl_nxt = !rx_tgl_r;
            end
          end
        end
        DS_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              st_nxt = DS_TXD;
              tx_nxt = txbuf_r;
              oe_nxt = !txbuf_r[7];
              tk_tgl_nxt = !tk_tgl_r;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = DS_RXD;
            end
          end
        end
        DS_TXD: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == `TSC_LAST_BIT) begin
              oe_nxt = 1'b0;
              st_nxt = DS_TXACK;
            end else begin
              oe_nxt = !tx_r[6];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        DS_TXACK: begin
          if (scl_rise) begin
            st_nxt = sda_f ? DS_IDLE : DS_TXNEXT;
          end
        end
        DS_TXNEXT: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            st_nxt = DS_TXD;
            tx_nxt = txbuf_r;
            oe_nxt = !txbuf_r[7];
            tk_tgl_nxt = !tk_tgl_r;
          end
        end
        default: begin
          st_nxt = DS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_LINK_CLK) begin
    if (lrst) begin
      ln_f_r <= 2'h3;
      ln_q_r <= 2'h3;
      st_r <= DS_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      txbuf_r <= 8'hff;
      oe_r <= 1'b0;
      rw_r <= 1'b0;
      rx_hold_r <= 8'h00;
      rx_first_r <= 1'b0;
      rx_tgl_r <= 1'b0;
      tk_tgl_r <= 1'b0;
      stp_tgl_r <= 1'b0;
      tout_r <= 20'h0;
    end else begin
      ln_f_r <= ln_f_nxt;
      ln_q_r <= ln_f_r;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      txbuf_r <= txbuf_nxt;
      oe_r <= oe_nxt;
      rw_r <= rw_nxt;
      rx_hold_r <= rx_hold_nxt;
      rx_first_r <= rx_first_nxt;
      rx_tgl_r <= rx_tgl_nxt;
      tk_tgl_r <= tk_tgl_nxt;
      stp_tgl_r <= stp_tgl_nxt;
      tout_r <= tout_nxt;
    end
  end

  // Data line only ever pulled low; clock never driven
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = oe_r;

  // ---------------- System clock domain ----------------
  logic [8:0] ev_s_r;
  logic [7:0] tx_hold_nxt;
  logic txw_tgl_nxt;
  logic alm_stk_r, alm_stk_nxt, alm_oe_nxt;

  // Event toggles from the link side: two sync stages, then edge stage
  always_ff @(posedge I_CLK) begin
    ev_s_r <= {ev_s_r[5:0], stp_tgl_r, tk_tgl_r, rx_tgl_r};
  end

  // Transmit byte hold and alarm mode selection
  always_comb begin
    tx_hold_nxt = I_TX_WR ? I_TX_DATA : tx_hold_r;
    txw_tgl_nxt = txw_tgl_r ^ I_TX_WR;
    // Event sets win over software clear
    alm_stk_nxt = (alm_stk_r && !I_ALARM_CLR) || I_TEMP_HIGH || I_TEMP_LOW;
    if (I_ALARM_MODE == `TSC_ALM_INT) begin
      alm_oe_nxt = alm_stk_nxt;
    end else if (I_ALARM_MODE == `TSC_ALM_CMP) begin
      alm_oe_nxt = I_TEMP_HIGH || I_TEMP_LOW;
    end else if (I_ALARM_MODE == `TSC_ALM_CRIT) begin
      alm_oe_nxt = I_TEMP_CRIT;
    end else begin
      alm_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_hold_r <= 8'hff;
      txw_tgl_r <= 1'b0;
      alm_stk_r <= 1'b0;
      O_ALARM_OE <= 1'b0;
      O_ALARM_O <= 1'b0;
      O_RX_DATA <= 8'h00;
      O_RX_FIRST <= 1'b0;
      O_RX_VALID <= 1'b0;
      O_TX_TAKEN <= 1'b0;
      O_STOP <= 1'b0;
    end else begin
      tx_hold_r <= tx_hold_nxt;
      txw_tgl_r <= txw_tgl_nxt;
      alm_stk_r <= alm_stk_nxt;
      O_ALARM_OE <= alm_oe_nxt;
      O_ALARM_O <= 1'b0;
      O_RX_VALID <= ev_s_r[6] ^ ev_s_r[3];
      O_TX_TAKEN <= ev_s_r[7] ^ ev_s_r[4];
      O_STOP <= ev_s_r[8] ^ ev_s_r[5];
      if (ev_s_r[6] ^ ev_s_r[3]) begin
        O_RX_DATA <= rx_hold_r;
        O_RX_FIRST <= rx_first_r;
      end
    end
  end

endmodule : tsc_target

// ### hw/tsc_master.sv
// Two-wire bus master end: makes the serial clock by division.
// Assumes one command at a time from user logic on I_CLK.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_master
  import tsc_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  tsc_i2c_if.host bus,
  input wire logic I_CMD_VALID,
  input wire tsc_cmd_t I_CMD,
  input wire logic [7:0] I_WDATA,
  input wire logic I_ACK_OUT,
  output logic O_READY,
  output logic O_DONE,
  output logic [7:0] O_RDATA,
  output logic O_ACK_IN
);

  localparam int unsigned QTR = `TSC_QTR_CYC;

  tsc_mstate_t st_r, st_nxt;
  logic [1:0] sda_s_r;
  logic [15:0] div_r, div_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [3:0] bits_r, bits_nxt;
  logic [8:0] sh_r, sh_nxt, rx_r, rx_nxt;
  logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt;
  logic rdy_nxt, done_nxt, ack_nxt;
  logic [7:0] rdata_nxt;
  logic tick;

  // Data line synchroniser
  always_ff @(posedge I_CLK) begin
    sda_s_r <= {sda_s_r[0], bus.sda};
  end

  assign tick = (div_r == 16'(QTR - 1));

  // Quarter-phase sequencer for start, bit and stop
  always_comb begin
    st_nxt = st_r;
    div_nxt = (st_r == MS_IDLE || tick) ? 16'h0 : div_r + 16'h1;
    ph_nxt = tick ? ph_r + 2'h1 : ph_r;
    bits_nxt = bits_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    scl_oe_nxt = scl_oe_r;
    sda_oe_nxt = sda_oe_r;
    rdy_nxt = O_READY;
    done_nxt = 1'b0;
    ack_nxt = O_ACK_IN;
    rdata_nxt = O_RDATA;
    case (st_r)
      MS_IDLE: begin
        ph_nxt = 2'h0;
        bits_nxt = 4'h0;
        if (I_CMD_VALID) begin
          rdy_nxt = 1'b0;
          case (I_CMD)
            CMD_START: st_nxt = MS_START;
            CMD_WRITE: begin
              st_nxt = MS_BIT;
              sh_nxt = {I_WDATA, 1'b1};
            end
            CMD_READ: begin
              st_nxt = MS_BIT;
              sh_nxt = {8'hff, I_ACK_OUT};
            end
            default: st_nxt = MS_STOP;
          endcase
        end
      end
      MS_START: begin
        if (tick) begin
          case (ph_r)
            2'h0: sda_oe_nxt = 1'b0;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b1;
            default: begin
              scl_oe_nxt = 1'b1;
              st_nxt = MS_IDLE;
              rdy_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      MS_BIT: begin
        if (tick) begin
          case (ph_r)
            2'h0: sda_oe_nxt = !sh_r[8];
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: rx_nxt = {rx_r[7:0], sda_s_r[1]};
            default: begin
              scl_oe_nxt = 1'b1;
              sh_nxt = {sh_r[7:0], 1'b1};
              bits_nxt = bits_r + 4'h1;
              if (bits_r == `TSC_LAST_BIT) begin
                st_nxt = MS_IDLE;
                sda_oe_nxt = 1'b0;
                rdy_nxt = 1'b1;
                done_nxt = 1'b1;
                rdata_nxt = rx_r[8:1];
                ack_nxt = rx_r[0];
              end
            end
          endcase
        end
      end
      MS_STOP: begin
        if (tick) begin
          case (ph_r)
            2'h0: sda_oe_nxt = 1'b1;
            2'h1: scl_oe_nxt = 1'b0;
            2'h2: sda_oe_nxt = 1'b0;
            default: begin
              st_nxt = MS_IDLE;
              rdy_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      default: st_nxt = MS_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      st_r <= MS_IDLE;
      div_r <= 16'h0;
      ph_r <= 2'h0;
      bits_r <= 4'h0;
      sh_r <= 9'h1ff;
      rx_r <= 9'h000;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      O_READY <= 1'b1;
      O_DONE <= 1'b0;
      O_ACK_IN <= 1'b1;
      O_RDATA <= 8'h00;
    end else begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      ph_r <= ph_nxt;
      bits_r <= bits_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      scl_oe_r <= scl_oe_nxt;
      sda_oe_r <= sda_oe_nxt;
      O_READY <= rdy_nxt;
      O_DONE <= done_nxt;
      O_ACK_IN <= ack_nxt;
      O_RDATA <= rdata_nxt;
    end
  end

  // Both lines open drain: only pulled low
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe_r;

endmodule : tsc_master

// ### tb/tsc_link_assertions.sv
// Concurrent checks on the two-wire link between master and target.
// Assumes resolved scl/sda lines sampled on the 200 MHz system clock.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module tsc_link_checker
  import tsc_pkg::*;
#(
  parameter int unsigned TOUT_CYC = 2000
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic [2:0] I_STRAP_ADDR
);
  // Six system clocks per link clock, plus filter slack
  localparam int TLIM = TOUT_CYC * 6 + 200;
  logic scl_d_r, sda_d_r, first_r, first_nxt, sel_r, sel_nxt;
  logic dir_r, dir_nxt, xfer_r, xfer_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [15:0] low_r, low_nxt;
  logic start_w, stop_w, rise_w, match_w;

  // Bus events from the resolved lines
  assign start_w = scl && scl_d_r && sda_d_r && !sda;
  assign stop_w = scl && scl_d_r && !sda_d_r && sda;
  assign rise_w = scl && !scl_d_r;
  assign match_w = sh_r[7:1] == {`TSC_DEV_TYPE, I_STRAP_ADDR};

  // Bit position, address byte and scl-low time
  always_comb begin
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    first_nxt = first_r;
    sel_nxt = sel_r;
    dir_nxt = dir_r;
    xfer_nxt = xfer_r;
    low_nxt = scl ? 16'h0000 : low_r + {15'h0000, low_r != 16'hffff};
    if (start_w) begin
      cnt_nxt = 4'h0;
      first_nxt = 1'b1;
      xfer_nxt = 1'b1;
    end else if (stop_w) begin
      xfer_nxt = 1'b0;
    end else if (rise_w && cnt_r == 4'h8) begin
      cnt_nxt = 4'h0;
      first_nxt = 1'b0;
      sel_nxt = first_r ? match_w : sel_r;
      dir_nxt = first_r ? sh_r[0] : dir_r;
    end else if (rise_w) begin
      cnt_nxt = cnt_r + 4'h1;
      sh_nxt = {sh_r[6:0], sda};
    end
  end

  // Tracking registers
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      first_r <= 1'b0;
      sel_r <= 1'b0;
      dir_r <= 1'b0;
      xfer_r <= 1'b0;
      low_r <= 16'h0000;
    end else begin
      scl_d_r <= scl;
      sda_d_r <= sda;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      first_r <= first_nxt;
      sel_r <= sel_nxt;
      dir_r <= dir_nxt;
      xfer_r <= xfer_nxt;
      low_r <= low_nxt;
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  // Ninth rise of the address byte, and master nack on a read
  sequence addr_ninth_s;
    rise_w && first_r && cnt_r == 4'h8;
  endsequence
  sequence rd_nack_s;
    rise_w && !first_r && cnt_r == 4'h8 && sel_r && dir_r && sda;
  endsequence

  sda_open_drain_a: assert property (d_sda_oe |-> !d_sda_o)
    else $error("target drives data line high");
  hold_high_a: assert property (scl && scl_d_r |-> $stable(d_sda_oe))
    else $error("target data changed while clock high");
  change_fall_a: assert property ($changed(d_sda_oe) |-> !$past(scl, 8))
    else $error("target data changed too soon after clock fall");
  drive_xfer_a: assert property (d_sda_oe |-> xfer_r)
    else $error("target drives outside a transfer");
  addr_ack_a: assert property (addr_ninth_s ##0 match_w |-> !sda)
    else $error("matching address not acknowledged");
  addr_nack_a: assert property (addr_ninth_s ##0 !match_w |-> sda)
    else $error("foreign address acknowledged");
  tout_release_a: assert property (low_r >= TLIM |-> !d_sda_oe)
    else $error("data line held after clock timeout");
  nack_release_a: assert property (rd_nack_s |-> ##300 !d_sda_oe)
    else $error("data line driven after master nack");
endmodule : tsc_link_checker

// ### tb/temp_sensor_i2c_target_port_tb.sv
// Testbench joining the master end and the target end on one link.
// Assumes the design under hw/ and the link checker under tb/.
`timescale 1ns/1ps
`include "tsc_defines.svh"
module temp_sensor_i2c_target_port_tb
  import tsc_pkg::*;
;
  localparam int unsigned TOUT = 2000;
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic cmd_valid = 1'b0;
  tsc_cmd_t cmd = CMD_START;
  logic [7:0] wdata = 8'h00;
  logic ack_out = 1'b0;
  logic [2:0] strap = 3'h5;
  logic [7:0] tx_data = 8'h00;
  logic tx_wr = 1'b0;
  logic t_hi = 1'b0, t_lo = 1'b0, t_crit = 1'b0, alm_clr = 1'b0;
  logic [1:0] alm_mode = 2'h3;
  logic rdy, done, ack_in, rx_valid, rx_first, tx_taken, stop_p;
  logic alm_oe, alm_o;
  logic [7:0] rdata, rx_data;
  int mismatches = 0;
  int check_count = 0;
  int stop_cnt = 0;
  logic [8:0] rx_q[$];
  logic [7:0] tx_q[$];
  bit tx_free = 1'b1;
  bit go;

  // System clock 5 ns, link clock 30 ns
  always #2.5 clk = ~clk;
  always #15 link_clk = ~link_clk;

  tsc_i2c_if bus_if ();
  tsc_master tsc_master_i (.I_CLK(clk), .I_SRST(srst), .bus(bus_if),
    .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_WDATA(wdata),
    .I_ACK_OUT(ack_out), .O_READY(rdy), .O_DONE(done), .O_RDATA(rdata),
    .O_ACK_IN(ack_in));
  tsc_target #(.TOUT_CYC(TOUT)) tsc_target_i (.I_CLK(clk), .I_SRST(srst),
    .I_LINK_CLK(link_clk), .bus(bus_if), .I_STRAP_ADDR(strap),
    .I_TX_DATA(tx_data), .I_TX_WR(tx_wr), .O_RX_DATA(rx_data),
    .O_RX_VALID(rx_valid), .O_RX_FIRST(rx_first), .O_TX_TAKEN(tx_taken),
    .O_STOP(stop_p), .I_TEMP_HIGH(t_hi), .I_TEMP_LOW(t_lo),
    .I_TEMP_CRIT(t_crit), .I_ALARM_MODE(alm_mode), .I_ALARM_CLR(alm_clr),
    .O_ALARM_O(alm_o), .O_ALARM_OE(alm_oe));
  tsc_link_checker #(.TOUT_CYC(TOUT)) chk_i (.I_CLK(clk), .I_SRST(srst),
    .scl(bus_if.scl), .sda(bus_if.sda), .d_sda_o(bus_if.d_sda_o),
    .d_sda_oe(bus_if.d_sda_oe), .I_STRAP_ADDR(strap));

  // Record received bytes and stop pulses
  always @(posedge clk) begin
    if (rx_valid === 1'b1) rx_q.push_back({rx_first, rx_data});
    if (stop_p === 1'b1) stop_cnt++;
  end

  // Hand the target one transmit byte per load taken
  always @(posedge clk) begin
    if (tx_taken === 1'b1) tx_free = 1'b1;
    go = tx_free && tx_q.size() > 0;
    tx_wr <= go;
    if (go) begin
      tx_data <= tx_q.pop_front();
      tx_free = 1'b0;
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // One master command: wait ready, pulse valid, wait done
  task automatic mcmd(input tsc_cmd_t c, input logic [7:0] d, input logic a);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 6000);
    cmd <= c;
    wdata <= d;
    ack_out <= a;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 12000);
    if (n >= 12000) begin
      mismatches++;
      $display("[ERR] %0t master command hung", $time);
      give_verdict();
    end
  endtask : mcmd

  task automatic wr(input logic [7:0] b, input logic a);
    mcmd(CMD_WRITE, b, 1'b0);
    chk1(ack_in, a);
  endtask : wr

  task automatic rd(input logic a, input logic [7:0] b);
    mcmd(CMD_READ, 8'h00, a);
    chk8(rdata, b);
  endtask : rd

  task automatic rxchk(input logic f, input logic [7:0] b);
    logic [8:0] e;
    e = (rx_q.size() > 0) ? rx_q.pop_front() : 9'h1ff;
    chk1(e[8], f);
    chk8(e[7:0], b);
  endtask : rxchk

  task automatic alarm(input logic [1:0] m, input logic [2:0] hlc,
                       input logic clr, input logic exp);
    @(posedge clk);
    alm_mode <= m;
    {t_hi, t_lo, t_crit} <= hlc;
    alm_clr <= clr;
    @(posedge clk);
    alm_clr <= 1'b0;
    @(posedge clk);
    chk1(alm_oe, exp);
    chk1(alm_o, 1'b0);
  endtask : alarm

  function automatic logic [7:0] adr(input logic [2:0] s, input logic r);
    return {`TSC_DEV_TYPE, s, r};
  endfunction : adr

  initial begin
    repeat (16) @(posedge link_clk);
    @(posedge clk);
    srst <= 1'b0;
    tick(40);
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h5, 1'b0), 1'b0);
    wr(8'h96, 1'b0);
    wr(8'h01, 1'b0);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    tick(60);
    chk8(8'(rx_q.size()), 8'h03);
    rxchk(1'b1, adr(3'h5, 1'b0));
    rxchk(1'b0, 8'h96);
    rxchk(1'b0, 8'h01);
    chk8(stop_cnt[7:0], 8'h01);
    $display("write test done");
    tx_q.push_back(8'h71);
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h5, 1'b1), 1'b0);
    tick(100);
    chk1(bus_if.sda, 1'b0);
    tick(TOUT * 6 + 600);
    chk1(bus_if.sda, 1'b1);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    tick(60);
    chk8(stop_cnt[7:0], 8'h01);
    rxchk(1'b1, adr(3'h5, 1'b1));
    $display("timeout test done");
    strap <= 3'h2;
    tx_q.push_back(8'hc8);
    tx_q.push_back(8'h3e);
    tick(20);
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h2, 1'b0), 1'b0);
    wr(8'h5a, 1'b0);
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h2, 1'b1), 1'b0);
    rd(1'b0, 8'hc8);
    rd(1'b1, 8'h3e);
    tick(100);
    chk1(bus_if.sda, 1'b1);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    tick(60);
    // Master nack already sent the target idle, so this stop adds no pulse
    chk8(stop_cnt[7:0], 8'h01);
    rxchk(1'b1, adr(3'h2, 1'b0));
    rxchk(1'b0, 8'h5a);
    rxchk(1'b1, adr(3'h2, 1'b1));
    $display("read test done");
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h5, 1'b0), 1'b1);
    mcmd(CMD_START, 8'h00, 1'b0);
    wr(adr(3'h2, 1'b0) ^ 8'h80, 1'b1);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    tick(60);
    chk8(stop_cnt[7:0], 8'h01);
    chk8(8'(rx_q.size()), 8'h00);
    $display("mismatch test done");
    alarm(2'h1, 3'b100, 1'b0, 1'b1);
    alarm(2'h1, 3'b010, 1'b0, 1'b1);
    alarm(2'h1, 3'b000, 1'b0, 1'b0);
    alarm(2'h2, 3'b100, 1'b0, 1'b0);
    alarm(2'h2, 3'b001, 1'b0, 1'b1);
    alarm(2'h3, 3'b001, 1'b0, 1'b0);
    alarm(2'h0, 3'b100, 1'b0, 1'b1);
    alarm(2'h0, 3'b000, 1'b0, 1'b1);
    alarm(2'h0, 3'b000, 1'b1, 1'b0);
    $display("alarm test done");
    give_verdict();
  end
endmodule : temp_sensor_i2c_target_port_tb
